// File: logic/tass_params.svh
`ifndef TASS_PARAMS_SVH
`define TASS_PARAMS_SVH

// Control byte field positions, most significant bit first on the wire
`define TASS_CTL_START_BIT 7
`define TASS_CTL_CHAN_HI 6
`define TASS_CTL_CHAN_LO 4
`define TASS_CTL_MODE_BIT 3
`define TASS_CTL_REF_BIT 2
`define TASS_CTL_REF_POWER_BIT 1
`define TASS_CTL_ADC_POWER_BIT 0

// Channel codes with special handling
`define TASS_CHAN_TEMP0 3'h0
`define TASS_CHAN_BATT 3'h2
`define TASS_CHAN_TEMP1 3'h7

// Sequence lengths in serial clocks
`define TASS_XFER_CLKS 8
`define TASS_CONV_CLKS 24
`define TASS_ACQ_CLKS 3
`define TASS_BITS_HI_RES 12
`define TASS_BITS_LO_RES 8
`define TASS_OVERLAP_CLKS 15
`define TASS_TEMP_BIAS_MULT 91

// Control bits seen before acquisition starts (start, chan, mode)
`define TASS_ACQ_AFTER_BITS 5

`endif

// File: logic/tass_pkg.sv
`default_nettype none
package tass_pkg;
    // Device sequencer phases
    typedef enum logic [1:0] {
        TASS_IDLE,
        TASS_CTRL,
        TASS_CONV
    } tass_phase_e;

    // Host transfer phases
    typedef enum logic [1:0] {
        TASS_H_IDLE,
        TASS_H_SEND,
        TASS_H_READ
    } tass_hphase_e;

    typedef logic [11:0] tass_result_t;
    typedef logic [7:0] tass_ctrl_t;
endpackage
`default_nettype wire

// File: logic/tass_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// Three-wire serial link; all lines are sampled on the serial clock
interface tass_link_if;
    logic serial_clock_in; // Host-made serial clock
    logic rst_n; // Shared synchronous reset, active low
    logic data_to_dev; // Host to device serial data
    logic data_to_host; // Device to host serial data
    logic busy; // Device converting
    modport dev (input serial_clock_in, input rst_n, input data_to_dev,
        output data_to_host, output busy);
    modport host (output data_to_dev, input serial_clock_in, input rst_n,
        input data_to_host, input busy);
endinterface
`default_nettype wire

// File: logic/tass_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "tass_params.svh"
module tass_device
    import tass_pkg::*;
(
    tass_link_if.dev link, // Serial link to host
    input wire tass_pkg::tass_result_t sample_in, // Converter code
    output logic ref_to_plates_out, // References tied to Y plates
    output logic x_drivers_out, // X plate drivers on
    output logic y_drivers_out, // Y plate drivers on
    output logic sample_hold_out, // High while holding
    output logic temp_bias_unit_out, // Diode bias at unit current
    output logic temp_bias_big_out, // Diode bias at large current
    output logic batt_div_out, // Battery divider on
    output logic ref_power_out, // Internal reference on
    output logic [2:0] mux_sel_out, // Multiplexer channel
    output logic eight_bit_out // Current conversion is 8-bit
);
    import tass_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        tass_phase_e phase; // Sequencer phase
        logic [3:0] cnt; // Clock count inside phase
        tass_ctrl_t sr; // Control shift register
        logic [2:0] chan; // Latched channel
        logic eight; // Latched resolution
        logic ref_se; // Latched reference mode, high single-ended
        logic adc_power_bit; // Latched adc power bit
        logic ref_power_bit; // Latched ref power bit
        logic ref_tie; // References tied to Y plates
        logic acq; // Acquisition active
        logic hold; // Sample held
        logic drv_x; // X drivers
        logic drv_y; // Y drivers
        logic bias_u; // Unit diode bias
        logic bias_b; // Large diode bias
        logic batt; // Battery divider
        logic sdo; // Serial output bit
        logic busy; // Busy flag
        tass_result_t res; // Result shift register
    } tass_dev_s;

    tass_dev_s st_q;
    tass_dev_s st_d;
    logic [7:0] byte_now; // Control byte including current bit

    ////////////////////////////////////////////////////////////////////
    // Driver selection per channel and reference mode
    function automatic logic [1:0] drv_of(input logic [2:0] ch,
                                          input logic se);
        logic [1:0] r; // {x, y}
        r = 2'h0;
        unique case (ch)
            3'h1: r = 2'h1; // Y plate for X-position
            3'h3: r = 2'h3; // Cross plates for Z1
            3'h4: r = 2'h3; // Cross plates for Z2
            3'h5: r = 2'h2; // X plate for Y-position
            default: r = 2'h0; // Non-touch channels
        endcase
        // Non-touch channels never drive plates, whatever the mode
        if (!se && (ch == 3'h0 || ch == 3'h2 ||
                    ch == 3'h6 || ch == 3'h7)) begin
            r = 2'h0; // Ratiometric only for touch channels
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [1:0] dv;
        dv = 2'h0;
        st_d = st_q;
        byte_now = {st_q.sr[6:0], link.data_to_dev};
        st_d.cnt = st_q.cnt + 4'h1;
        unique case (st_q.phase)
            TASS_IDLE: begin
                st_d.cnt = 4'h0;
                // Wait for start bit
                if (link.data_to_dev) begin
                    st_d.phase = TASS_CTRL;
                    st_d.sr = 8'h01;
                    st_d.cnt = 4'h1;
                end
            end
            TASS_CTRL: begin
                st_d.sr = byte_now;
                // Channel and mode known: sampling begins
                if (st_q.cnt == 4'(`TASS_ACQ_AFTER_BITS - 1)) begin
                    // Channel bits were the three shifted in before mode
                    st_d.chan = st_q.sr[2:0];
                    st_d.ref_se = 1'b1;
                    st_d.acq = 1'b1;
                    st_d.hold = 1'b0;
                end
                if (st_q.cnt == 4'(`TASS_ACQ_AFTER_BITS)) begin
                    // Reference bit arrives: set refs, drivers, biases
                    st_d.ref_se = link.data_to_dev;
                    st_d.eight = st_q.sr[0];
                    dv = drv_of(st_q.chan, link.data_to_dev);
                    st_d.drv_x = dv[1];
                    st_d.drv_y = dv[0];
                    st_d.bias_u = link.data_to_dev &&
                        st_q.chan == `TASS_CHAN_TEMP0;
                    st_d.bias_b =
                        st_q.chan == `TASS_CHAN_TEMP1;
                    st_d.batt = st_q.chan == `TASS_CHAN_BATT;
                end
                if (st_q.cnt == 4'(`TASS_XFER_CLKS - 1)) begin
                    // Byte complete after three acquire clocks
                    // Power bits latched as busy rises
                    st_d.ref_power_bit = byte_now[`TASS_CTL_REF_POWER_BIT];
                    st_d.adc_power_bit = byte_now[`TASS_CTL_ADC_POWER_BIT];
                    st_d.acq = 1'b0;
                    st_d.hold = 1'b1;
                    st_d.bias_u = 1'b0;
                    st_d.bias_b = 1'b0;
                    st_d.batt = 1'b0;
                    if (st_q.ref_se) begin
                        st_d.drv_x = 1'b0;
                        st_d.drv_y = 1'b0;
                    end
                    st_d.busy = 1'b1;
                    st_d.res = sample_in;
                    st_d.phase = TASS_CONV;
                    st_d.cnt = 4'h0;
                end
            end
            TASS_CONV: begin
                // Result bits, MSB first, one per clock
                st_d.busy = 1'b0;
                st_d.sdo = st_q.res[11];
                st_d.res = {st_q.res[10:0], 1'b0};
                st_d.sr = byte_now;
                // Last bit: 12 (or 8) clocks plus the trailing bit
                if (st_q.cnt == (st_q.eight ? 4'(`TASS_BITS_LO_RES)
                                            : 4'(`TASS_BITS_HI_RES))) begin
                    st_d.hold = 1'b0;
                    st_d.sdo = 1'b0;
                    // Drivers stay on only while adc kept powered
                    if (!st_q.adc_power_bit) begin
                        st_d.drv_x = 1'b0;
                        st_d.drv_y = 1'b0;
                    end
                    st_d.phase = TASS_IDLE;
                    st_d.cnt = 4'h0;
                    // Overlapped start bit seen at clock 13 or 9
                    if (link.data_to_dev) begin
                        st_d.phase = TASS_CTRL;
                        st_d.sr = 8'h01;
                        st_d.cnt = 4'h1;
                    end
                end
            end
            default: st_d = st_q;
        endcase
        // Reference tie kept as a field so the pin comes from a flop
        st_d.ref_tie = (st_d.acq | st_d.hold) & ~st_d.ref_se;
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    // Reset is synchronous; all fields clear, outputs idle low
    always_ff @(posedge link.serial_clock_in) begin
        if (!link.rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    // Each pin mirrors one field of the state register
    assign link.data_to_host = st_q.sdo;
    assign link.busy = st_q.busy;
    assign ref_to_plates_out = st_q.ref_tie;
    assign x_drivers_out = st_q.drv_x;
    assign y_drivers_out = st_q.drv_y;
    assign sample_hold_out = st_q.hold;
    assign temp_bias_unit_out = st_q.bias_u;
    assign temp_bias_big_out = st_q.bias_b;
    assign batt_div_out = st_q.batt;
    assign ref_power_out = st_q.ref_power_bit;
    assign mux_sel_out = st_q.chan;
    assign eight_bit_out = st_q.eight;
endmodule
`default_nettype wire

// File: logic/tass_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "tass_params.svh"
module tass_host
    import tass_pkg::*;
(
    tass_link_if.host link, // Serial link to device
    input wire logic start_in, // Pulse: begin one conversion
    input wire tass_pkg::tass_ctrl_t ctrl_in, // Control byte to send
    output logic ready_out, // Idle, may start
    output logic done_out, // Pulse: result valid
    output tass_pkg::tass_result_t result_out // Received result
);
    import tass_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        tass_hphase_e phase; // Host phase
        logic [4:0] cnt; // Clock count in phase
        tass_ctrl_t sr; // Outgoing byte
        tass_result_t rx; // Incoming bits
        logic dout; // Serial data out
        logic done; // Result strobe
        logic rdy; // Idle, registered for the pin
    } tass_host_s;

    tass_host_s st_q;
    tass_host_s st_d;

    ////////////////////////////////////////////////////////////////////
    // Next state: byte out, then read 16 clocks
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.cnt = st_q.cnt + 5'h1;
        unique case (st_q.phase)
            TASS_H_IDLE: begin
                st_d.cnt = 5'h0;
                st_d.dout = 1'b0;
                if (start_in) begin
                    // Start bit forced high
                    st_d.sr = ctrl_in | 8'h80;
                    st_d.dout = 1'b1;
                    st_d.phase = TASS_H_SEND;
                    st_d.sr = {ctrl_in[6:0], 1'b0};
                end
            end
            TASS_H_SEND: begin
                // Remaining control bits, MSB first
                st_d.dout = st_q.sr[7];
                st_d.sr = {st_q.sr[6:0], 1'b0};
                if (st_q.cnt == 5'(`TASS_XFER_CLKS - 1)) begin
                    st_d.dout = 1'b0;
                    st_d.phase = TASS_H_READ;
                    st_d.cnt = 5'h0;
                end
            end
            TASS_H_READ: begin
                // Clocks 9..24 read the result
                st_d.rx = {st_q.rx[10:0], link.data_to_host};
                if (st_q.cnt == 5'(`TASS_BITS_HI_RES)) begin
                    st_d.done = 1'b1;
                end
                if (st_q.cnt == 5'(`TASS_CONV_CLKS - `TASS_XFER_CLKS - 1))
                begin
                    st_d.phase = TASS_H_IDLE;
                    st_d.rx = st_q.rx;
                end
            end
            default: st_d = st_q;
        endcase
        // Ready follows the next phase so the pin is a flop
        st_d.rdy = st_d.phase == TASS_H_IDLE;
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge link.serial_clock_in) begin
        if (!link.rst_n) begin
            st_q <= '0;
            st_q.rdy <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.data_to_dev = st_q.dout;
    assign ready_out = st_q.rdy;
    assign done_out = st_q.done;
    assign result_out = st_q.rx;
endmodule
`default_nettype wire

// File: tb/tass_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Watches the serial link between the host and the device ends
module tass_link_assertions (
    input wire logic serial_clock_in, // Serial clock
    input wire logic rst_n, // Sync reset, low
    input wire logic data_to_dev, // Host to device data
    input wire logic data_to_host, // Device to host data
    input wire logic busy // Device converting
);
////////////////////////////////////////////////////////////////////////
    // Busy is a single-clock pulse at hold entry
    a_busy_pulse: assert property (@(posedge serial_clock_in)
        disable iff (!rst_n) busy |=> !busy)
        else $error("busy held longer than one clock");
    // Overlapped conversions still leave at least ten clocks
    a_busy_spacing: assert property (@(posedge serial_clock_in)
        disable iff (!rst_n) busy |=> !busy [*8] ##1 !busy [*2])
        else $error("busy pulses too close together");
    // Busy comes eight clocks after the start bit
    a_byte_start: assert property (@(posedge serial_clock_in)
        disable iff (!rst_n) $rose(busy) |-> $past(data_to_dev, 8))
        else $error("busy without a start bit eight clocks earlier");
    // Host sends nothing for eight clocks after busy, while the result streams back
    a_host_quiet: assert property (@(posedge serial_clock_in)
        disable iff (!rst_n) busy |=> !data_to_dev [*8])
        else $error("host data during result transfer");
    // A full control byte is needed after reset
    a_reset_hold: assert property (@(posedge serial_clock_in)
        $rose(rst_n) |-> !busy [*8])
        else $error("busy too soon after reset");
    // Reset clears the busy line
    a_reset_busy: assert property (@(posedge serial_clock_in)
        !rst_n |=> !busy)
        else $error("busy not cleared by reset");
    // Reset clears the result line
    a_reset_dout: assert property (@(posedge serial_clock_in)
        !rst_n |=> !data_to_host)
        else $error("result line not cleared by reset");
    // Reset leaves the command line idle low
    a_reset_din: assert property (@(posedge serial_clock_in)
        !rst_n |=> !data_to_dev)
        else $error("command line not idle after reset");
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import tass_pkg::*;
////////////////////////////////////////////////////////////////////////
    logic clock_in = 1'b0; // Serial clock
    logic rst_n_in = 1'b0; // Reset, low
    logic start_in = 1'b0; // Host start pulse
    tass_ctrl_t ctrl_in = 8'h00; // Control byte
    tass_result_t sample_in = 12'h000; // Converter code
    logic ready_out;
    logic done_out;
    tass_result_t result_out;
    logic ref_to_plates_out;
    logic x_drivers_out;
    logic y_drivers_out;
    logic sample_hold_out;
    logic temp_bias_unit_out;
    logic temp_bias_big_out;
    logic batt_div_out;
    logic ref_power_out;
    logic [2:0] mux_sel_out;
    logic eight_bit_out;
    int error_cnt = 0;
    int checks_done = 0;
    int done_cnt = 0; // Result pulses seen
    int n_unit = 0; // Clocks of unit bias
    int n_big = 0; // Clocks of large bias
    int n_batt = 0; // Clocks of divider on
    tass_ctrl_t cur = 8'h00; // Byte in flight
    tass_result_t exp_q[$]; // Model results
    tass_result_t msk_q[$]; // Result bits that count
    logic [2:0] dch[4] = '{3'h1, 3'h3, 3'h4, 3'h5}; // Ratiometric channels
////////////////////////////////////////////////////////////////////////
    tass_link_if link ();
    assign link.serial_clock_in = clock_in;
    assign link.rst_n = rst_n_in;
    tass_device tass_device_i (.link(link), .sample_in(sample_in),
        .ref_to_plates_out(ref_to_plates_out),
        .x_drivers_out(x_drivers_out), .y_drivers_out(y_drivers_out),
        .sample_hold_out(sample_hold_out),
        .temp_bias_unit_out(temp_bias_unit_out),
        .temp_bias_big_out(temp_bias_big_out),
        .batt_div_out(batt_div_out), .ref_power_out(ref_power_out),
        .mux_sel_out(mux_sel_out), .eight_bit_out(eight_bit_out));
    tass_host tass_host_i (.link(link), .start_in(start_in),
        .ctrl_in(ctrl_in), .ready_out(ready_out), .done_out(done_out),
        .result_out(result_out));
    tass_link_assertions tass_link_assertions_i (
        .serial_clock_in(link.serial_clock_in), .rst_n(link.rst_n),
        .data_to_dev(link.data_to_dev), .data_to_host(link.data_to_host),
        .busy(link.busy));
////////////////////////////////////////////////////////////////////////
    // Free-running clock
    always #5 clock_in = ~clock_in;
    // Compare and count
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        checks_done++;
        if (seen !== want) begin
            error_cnt++;
            $display("wrong value at %0t ns: check %0d seen %h want %h",
                $time, checks_done, seen, want);
        end
    endtask
    // Expected {x, y} drivers while holding
    function automatic logic [1:0] drv_exp(input tass_ctrl_t c);
        if (c[2])
            return 2'b00;
        case (c[6:4])
            3'h1: return 2'b01;
            3'h5: return 2'b10;
            3'h3, 3'h4: return 2'b11;
            default: return 2'b00;
        endcase
    endfunction
////////////////////////////////////////////////////////////////////////
    // Monitor on the falling edge, where outputs have settled
    always @(negedge clock_in) begin
        if (rst_n_in) begin
            n_unit += int'(temp_bias_unit_out === 1'b1);
            n_big += int'(temp_bias_big_out === 1'b1);
            n_batt += int'(batt_div_out === 1'b1);
        end
        if (rst_n_in && link.busy === 1'b1) begin
            check(12'(sample_hold_out), 12'h001);
            check(12'(mux_sel_out), 12'(cur[6:4]));
            check(12'(eight_bit_out), 12'(cur[3]));
            check(12'(temp_bias_unit_out|temp_bias_big_out), 12'h0);
            check(12'(batt_div_out), 12'h000);
            check(12'(ref_to_plates_out), 12'(!cur[2]));
            check(12'({x_drivers_out, y_drivers_out}),
                12'(drv_exp(cur)));
            check(12'(ref_power_out), 12'(cur[1]));
        end
        if (rst_n_in && done_out === 1'b1) begin
            done_cnt++;
            if (exp_q.size() == 0)
                check(12'h001, 12'h000);
            else
                check(result_out&msk_q[0], exp_q.pop_front());
            if (msk_q.size() != 0)
                void'(msk_q.pop_front());
            check(12'(n_unit != 0), 12'(cur[6:4] == 3'h0 && cur[2]));
            check(12'(n_big != 0), 12'(cur[6:4] == 3'h7));
            check(12'(n_batt != 0), 12'(cur[6:4] == 3'h2));
        end
    end
////////////////////////////////////////////////////////////////////////
    // One conversion; poke retries start while the host is busy
    task automatic run(input tass_ctrl_t c, input bit poke);
        int n;
        int d0;
        tass_result_t s;
        tass_result_t m;
        n = 0;
        s = 12'($urandom);
        m = c[3] ? 12'hff0 : 12'hfff;
        while (ready_out !== 1'b1 && n < 200) begin
            @(negedge clock_in);
            n++;
        end
        cur = c;
        n_unit = 0;
        n_big = 0;
        n_batt = 0;
        d0 = done_cnt;
        exp_q.push_back(s & m);
        msk_q.push_back(m);
        @(posedge clock_in);
        start_in <= 1'b1;
        ctrl_in <= c;
        sample_in <= s;
        @(posedge clock_in);
        start_in <= 1'b0;
        if (poke) begin
            repeat (10) @(posedge clock_in);
            start_in <= 1'b1;
            @(posedge clock_in);
            start_in <= 1'b0;
        end
        n = 0;
        while (done_cnt == d0 && n < 300) begin
            @(negedge clock_in);
            n++;
        end
        check(12'(n < 300), 12'h001);
        if (!c[2] && drv_exp(c) != 2'b00)
            check(12'(x_drivers_out | y_drivers_out), 12'(c[0]));
        $display("test with byte %h done", c);
    endtask
    // Closing verdict
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'he6debd6d));
        repeat (6) @(posedge clock_in);
        rst_n_in <= 1'b1;
        for (int ch = 0; ch < 8; ch++)
            run({1'b1, 3'(ch), 1'b0, 1'b1, 2'(ch)}, 1'b0);
        for (int i = 0; i < 4; i++)
            run({1'b1, dch[i], 1'b0, 1'b0, 2'b01}, 1'b0);
        run({1'b1, 3'h1, 1'b1, 1'b0, 2'b00}, 1'b1);
        // Cut a conversion short by a reset in mid-run
        while (ready_out !== 1'b1)
            @(negedge clock_in);
        cur = 8'hd7;
        @(posedge clock_in);
        start_in <= 1'b1;
        ctrl_in <= 8'hd7;
        @(posedge clock_in);
        start_in <= 1'b0;
        repeat (12) @(posedge clock_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(negedge clock_in);
        check(12'({ready_out, link.busy}), 12'h002);
        $display("test with mid-run reset done");
        for (int i = 0; i < 6; i++)
            run({1'b1, 3'($urandom), 2'($urandom), 1'b1, 1'b1}, 1'b0);
        wrap_up();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock_in);
        error_cnt++;
        $display("wrong value at %0t ns: watchdog ran out", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
